// *** rtl/output_driver_ref_divider_cfg.v ***
/*
  output driver mode, swing and reference predivider configuration bank,
  with decoded controls for the analog driver and predivider.
  assumes the serial port front end delivers byte reads and writes as
  one-cycle strobes on core_clk_i; clock pin inputs come from the divider
  datapath on the same clock.
*/
`timescale 1ns/1ps
`include "odrv_cfg_map.vh"
module output_driver_ref_divider_cfg (
  // clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // register port from the serial processor front end
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  output wire reg_ack_o,
  // divided clock from the output divider
  input wire div_clk_i,
  // driver pins, already shaped for cmos phasing
  output wire clock_pin_true_o,
  output wire clock_pin_complement_o,
  // driver analog controls
  output wire drv_hcsl_en_o,
  output wire drv_lvds_en_o,
  output wire drv_cmos_en_o,
  output wire drv_type_bad_o,
  output wire drv_bias_en_o,
  output wire hcsl_term_en_o,
  output wire [1:0] lvds_common_level_o,
  output wire [9:0] lvds_common_mv_o,
  output wire lvds_swing_hi_o,
  output wire [9:0] lvds_swing_mv_o,
  output wire [3:0] hcsl_swing_o,
  output wire [9:0] hcsl_swing_mv_o,
  // reference predivider controls
  output wire prediv_hold_o,
  output wire prediv_run_o
);
  // synchronised reset copy used by every flop below except the two synchroniser flops
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  // stored register contents
  wire [7:0] mode_q;
  wire [7:0] swing_q;
  reg prediv_setb_reg;
  reg prediv_enb_reg;

  // register port response
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  reg ack_reg;

  // pin shaping and retiming
  reg pin_t_reg;
  reg pin_c_reg;
  reg pin_t_next;
  reg pin_c_next;

  // millivolt monitor views
  reg [9:0] cm_mv_reg;
  reg [9:0] hsw_mv_reg;
  reg [9:0] lsw_mv_reg;
  reg [9:0] cm_mv_next;
  reg [9:0] hsw_mv_next;

  // decoded fields and driver type selects
  wire [1:0] drv_type;
  wire [1:0] phase;
  wire [3:0] hsw;
  reg hcsl_sel;
  reg lvds_sel;
  reg cmos_sel;
  reg type_bad;

  // predivider word view and write strobes
  wire [31:0] prediv_word;
  wire wr_mode;
  wire wr_swing;
  wire wr_pd2;

  // reset release through two flops; assertion stays asynchronous
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // write strobes per byte address
  assign wr_mode = reg_wr_i && (reg_addr_i == `ADDR_MODE_CFG);
  assign wr_swing = reg_wr_i && (reg_addr_i == `ADDR_SWING_CFG);
  assign wr_pd2 = reg_wr_i && (reg_addr_i == `ADDR_PREDIV_B2);

  // driver mode register, all fields writable
  cfg_byte_reg #(
    .RESET_VAL(`MODE_RESET),
    .WR_MASK(8'hff)
  ) u_mode (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .wr_i(wr_mode),
    .wdata_i(reg_wdata_i),
    .q_o(mode_q)
  );

  // swing register; reserved low bits stored as written, default 0x4
  cfg_byte_reg #(
    .RESET_VAL(`SWING_RESET),
    .WR_MASK(8'hff)
  ) u_swing (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .wr_i(wr_swing),
    .wdata_i(reg_wdata_i),
    .q_o(swing_q)
  );

  // predivider controls live in byte 2 (bits 23:16 of the word)
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prediv_setb_reg <= `PD_SETB_RESET; // RULE9
      prediv_enb_reg <= `PD_ENB_RESET; // RULE10
    end else if (wr_pd2) begin
      prediv_setb_reg <= reg_wdata_i[`F_PD_SETB - `PD_BYTE2_LSB];
      prediv_enb_reg <= reg_wdata_i[`F_PD_ENB - `PD_BYTE2_LSB];
    end
  end

  // reserved read-only bits of the predivider word are tied to zero
  assign prediv_word = {9'h000, prediv_setb_reg, prediv_enb_reg, 21'h000000}; // RULE11

  // read mux; unmapped offsets read zero
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr_i)
      `ADDR_MODE_CFG: rdata_next = mode_q;
      `ADDR_SWING_CFG: rdata_next = swing_q;
      `ADDR_PREDIV_B0: rdata_next = prediv_word[7:0];
      `ADDR_PREDIV_B1: rdata_next = prediv_word[15:8];
      `ADDR_PREDIV_B2: rdata_next = prediv_word[23:16];
      `ADDR_PREDIV_B3: rdata_next = prediv_word[31:24];
      default: rdata_next = 8'h00;
    endcase
  end

  // registered read data and one-cycle acknowledge for reads and writes
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= reg_rd_i | reg_wr_i;
      if (reg_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end
  assign reg_rdata_o = rdata_reg;
  assign reg_ack_o = ack_reg;

  // field extraction
  assign drv_type = mode_q[`F_TYPE_HI:`F_TYPE_LO];
  assign phase = mode_q[`F_PH_HI:`F_PH_LO];
  assign hsw = swing_q[`F_HSW_HI:`F_HSW_LO];

  // driver type decode; reserved code enables no driver and flags itself
  // software may still write the reserved code, so it must fail safe here
  always @* begin
    hcsl_sel = 1'b0;
    lvds_sel = 1'b0;
    cmos_sel = 1'b0;
    type_bad = 1'b0;
    case (drv_type)
      `TYPE_HCSL: hcsl_sel = 1'b1; // RULE1
      `TYPE_LVDS: lvds_sel = 1'b1; // RULE1
      `TYPE_CMOS: cmos_sel = 1'b1; // RULE1
      default: type_bad = 1'b1; // RULE1
    endcase
  end
  assign drv_hcsl_en_o = hcsl_sel;
  assign drv_lvds_en_o = lvds_sel;
  assign drv_cmos_en_o = cmos_sel;
  assign drv_type_bad_o = type_bad;

  assign drv_bias_en_o = mode_q[`F_BIAS]; // RULE6
  assign hcsl_term_en_o = mode_q[`F_TERM] & drv_hcsl_en_o; // RULE5

  // lvds controls only act in lvds type, else parked at zero
  assign lvds_common_level_o = drv_lvds_en_o ? mode_q[`F_CM_HI:`F_CM_LO] : 2'h0; // RULE4
  assign lvds_swing_hi_o = drv_lvds_en_o & swing_q[`F_LAMP]; // RULE8
  assign lvds_swing_mv_o = lsw_mv_reg; // RULE8
  assign hcsl_swing_o = hsw; // RULE7

  // hcsl swing in mV; linear up to code 0xd, top two codes step by 25 mV
  always @* begin
    case (hsw)
      4'hd: hsw_mv_next = `HSW_MV_CODE_D; // RULE7
      4'he: hsw_mv_next = `HSW_MV_CODE_E; // RULE7
      4'hf: hsw_mv_next = `HSW_MV_CODE_F; // RULE7
      default: hsw_mv_next = `HSW_MV_BASE + {6'h00, hsw} * `HSW_MV_STEP; // RULE7
    endcase
  end

  // lvds common level in mV, one step per code
  always @* begin
    cm_mv_next = `CM_MV_BASE + {8'h00, mode_q[`F_CM_HI:`F_CM_LO]} * `CM_MV_STEP; // RULE4
  end

  // millivolt views registered so monitors never see a half-decoded byte;
  // they lag the register by one cycle, which monitoring tolerates
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cm_mv_reg <= `CM_MV_RESET;
      hsw_mv_reg <= `HSW_MV_RESET;
      lsw_mv_reg <= 10'h000;
    end else begin
      cm_mv_reg <= cm_mv_next;
      hsw_mv_reg <= hsw_mv_next;
      if (!drv_lvds_en_o) begin
        lsw_mv_reg <= 10'h000;
      end else if (swing_q[`F_LAMP]) begin
        lsw_mv_reg <= `LSW_MV_HI; // RULE8
      end else begin
        lsw_mv_reg <= `LSW_MV_LO; // RULE8
      end
    end
  end
  assign lvds_common_mv_o = drv_lvds_en_o ? cm_mv_reg : 10'h000;
  assign hcsl_swing_mv_o = hsw_mv_reg;

  // pin shaping: cmos uses phasing, differential types drive a true pair;
  // a held pin is driven low rather than floated, so the board sees a level
  // even while software is halfway through changing the driver type
  always @* begin
    pin_t_next = div_clk_i;
    pin_c_next = ~div_clk_i;
    if (drv_cmos_en_o) begin
      case (phase)
        `PH_SAME: begin
          pin_t_next = div_clk_i; // RULE2
          pin_c_next = div_clk_i; // RULE2
        end
        `PH_OPP: begin
          pin_t_next = div_clk_i; // RULE2
          pin_c_next = ~div_clk_i; // RULE2
        end
        `PH_TRUE: begin
          pin_t_next = div_clk_i; // RULE3
          pin_c_next = 1'b0; // RULE3
        end
        `PH_COMP: begin
          pin_t_next = 1'b0; // RULE3
          pin_c_next = ~div_clk_i; // RULE3
        end
        default: begin
          pin_t_next = 1'b0;
          pin_c_next = 1'b0;
        end
      endcase
    end else if (drv_type_bad_o) begin
      pin_t_next = 1'b0;
      pin_c_next = 1'b0;
    end
  end

  // pins retimed one cycle; bias off parks both low
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_t_reg <= 1'b0;
      pin_c_reg <= 1'b0;
    end else begin
      pin_t_reg <= pin_t_next & drv_bias_en_o; // RULE6
      pin_c_reg <= pin_c_next & drv_bias_en_o; // RULE6
    end
  end
  assign clock_pin_true_o = pin_t_reg;
  assign clock_pin_complement_o = pin_c_reg;

  // active-low predivider controls turned into positive actions
  assign prediv_hold_o = ~prediv_setb_reg; // RULE9
  assign prediv_run_o = ~prediv_enb_reg; // RULE10
endmodule // output_driver_ref_divider_cfg

// *** include/odrv_cfg_map.vh ***
/*
  register offsets, field positions and reset values for the output driver
  and reference predivider configuration bank.
  assumes a byte-wide register port with 16-bit offsets in the device.
*/
// Functional notes
// RULE1: driver type field decodes 0 hcsl, 2 lvds, 3 cmos; 1 reserved; resets hcsl.
// RULE2: cmos phasing code 0 drives pair in phase, 1 in opposite phase; resets 1.
// RULE3: cmos phasing 2 drives only true pin, 3 only complement; other held low.
// RULE4: lvds common level code 0..3 selects 700..1000 mV; resets 900 mV.
// RULE5: hcsl termination bit set connects internal 50 ohm to ground; resets 1.
// RULE6: bias enable bit turns on driver bias; resets 1.
// RULE7: four-bit hcsl swing, 200 mV plus about 50 mV per code; resets 0xb.
// RULE8: lvds swing bit selects 350 mV or 400 mV; resets 0.
// RULE9: predivider hold bit 22 active low holds divider set; resets 1.
// RULE10: predivider enable bit 21 active low runs divider; resets 0.
// RULE11: software keeps reserved rw defaults; reserved ro bits read zero.
`ifndef ODRV_CFG_MAP_VH
`define ODRV_CFG_MAP_VH

// byte offsets inside the local register window (chosen)
`define ADDR_MODE_CFG 16'h0000
`define ADDR_SWING_CFG 16'h0001
`define ADDR_PREDIV_B0 16'h0004
`define ADDR_PREDIV_B1 16'h0005
`define ADDR_PREDIV_B2 16'h0006
`define ADDR_PREDIV_B3 16'h0007

// driver mode register layout
`define MODE_RESET 8'h6c
`define F_TYPE_HI 1
`define F_TYPE_LO 0
`define F_BIAS 2
`define F_TERM 3
`define F_CM_HI 5
`define F_CM_LO 4
`define F_PH_HI 7
`define F_PH_LO 6

// driver type codes
`define TYPE_HCSL 2'h0
`define TYPE_LVDS 2'h2
`define TYPE_CMOS 2'h3

// cmos phasing codes
`define PH_SAME 2'h0
`define PH_OPP 2'h1
`define PH_TRUE 2'h2
`define PH_COMP 2'h3

// swing register layout
`define SWING_RESET 8'hb4
`define F_HSW_HI 7
`define F_HSW_LO 4
`define F_LAMP 3
`define F_SRES_HI 2
`define F_SRES_LO 0

// predivider register layout: only bits 22 and 21 are stored
`define F_PD_SETB 22
`define F_PD_ENB 21
`define PD_SETB_RESET 1'b1
`define PD_ENB_RESET 1'b0
`define PD_BYTE2_LSB 16

// millivolt monitor scaling and reset views
`define CM_MV_BASE 10'd700
`define CM_MV_STEP 10'd100
`define CM_MV_RESET 10'd900
`define HSW_MV_BASE 10'd200
`define HSW_MV_STEP 10'd50
`define HSW_MV_RESET 10'd750
`define HSW_MV_CODE_D 10'd850
`define HSW_MV_CODE_E 10'd875
`define HSW_MV_CODE_F 10'd900
`define LSW_MV_LO 10'd350
`define LSW_MV_HI 10'd400

`endif

// *** rtl/cfg_byte_reg.v ***
/*
  one byte-wide configuration register with write mask and reset value.
  assumes writes arrive as single-cycle strobes on the core clock.
*/
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // write side
  input wire wr_i,
  input wire [7:0] wdata_i,
  // stored value
  output wire [7:0] q_o
);
  reg [7:0] q_reg;
  wire [7:0] q_next;

  // masked bits keep their reset value, so they read as the fixed default
  assign q_next = (q_reg & ~WR_MASK) | (wdata_i & WR_MASK);

  // storage with asynchronous clear to the reset value
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= RESET_VAL;
    end else if (wr_i) begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule // cfg_byte_reg

// *** verif/odrv_cfg_sva.sv ***
/* port assertions for the driver config bank.
   assumes bind to output_driver_ref_divider_cfg, one clock. */
`timescale 1ns/1ps
module odrv_cfg_sva (
  // clock, reset, register port
  input wire core_clk_i,
  input wire nrst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_ack_o,
  // pins and controls
  input wire div_clk_i,
  input wire clock_pin_true_o,
  input wire clock_pin_complement_o,
  input wire drv_hcsl_en_o,
  input wire drv_lvds_en_o,
  input wire drv_cmos_en_o,
  input wire drv_type_bad_o,
  input wire drv_bias_en_o,
  input wire hcsl_term_en_o,
  input wire [1:0] lvds_common_level_o,
  input wire [9:0] lvds_common_mv_o,
  input wire lvds_swing_hi_o,
  input wire [3:0] hcsl_swing_o,
  input wire [9:0] hcsl_swing_mv_o,
  input wire prediv_hold_o,
  input wire prediv_run_o
);
  reg [1:0] live_reg;
  // pins stay low through the reset synchroniser, so skip those edges
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      live_reg <= 2'h0;
    end else if (live_reg != 2'h3) begin
      live_reg <= live_reg + 2'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_req; reg_wr_i || reg_rd_i; endsequence
  sequence s_mode_wr; reg_wr_i && reg_addr_i == 16'h0000; endsequence
  sequence s_pd_wr; reg_wr_i && reg_addr_i == 16'h0006; endsequence
  sequence s_cmos_wr; s_mode_wr ##0 reg_wdata_i[2:0] == 3'h7; endsequence
  chk_ack_pulse: assert property (s_req |=> reg_ack_o) else $error("ack missing");
  chk_ack_quiet: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o) else $error("stray ack");
  chk_type_decode: assert property (s_mode_wr |=> {drv_hcsl_en_o, drv_lvds_en_o,
    drv_cmos_en_o, drv_type_bad_o} == {$past(reg_wdata_i[1:0]) == 2'h0,
    $past(reg_wdata_i[1:0]) == 2'h2, $past(reg_wdata_i[1:0]) == 2'h3,
    $past(reg_wdata_i[1:0]) == 2'h1}) else $error("type decode wrong");
  chk_bias_bit: assert property (s_mode_wr |=> drv_bias_en_o == $past(reg_wdata_i[2]))
    else $error("bias wrong");
  chk_term_gate: assert property (s_mode_wr |=> hcsl_term_en_o ==
    ($past(reg_wdata_i[3]) && $past(reg_wdata_i[1:0]) == 2'h0)) else $error("term wrong");
  chk_lvds_gate: assert property (!drv_lvds_en_o |-> lvds_common_level_o == 2'h0
    && !lvds_swing_hi_o) else $error("lvds control outside lvds");
  chk_lvds_level: assert property (drv_lvds_en_o && $past(drv_lvds_en_o)
    && $stable(lvds_common_level_o) |-> lvds_common_mv_o == 10'd700 + 10'd100 *
    lvds_common_level_o) else $error("common level mv wrong");
  chk_pin_follow: assert property (live_reg == 2'h3 && drv_hcsl_en_o && drv_bias_en_o
    && $past(drv_hcsl_en_o && drv_bias_en_o) |-> clock_pin_true_o == $past(div_clk_i)
    && clock_pin_complement_o == !$past(div_clk_i)) else $error("pins wrong");
  chk_prediv_bits: assert property (s_pd_wr |=> prediv_hold_o == !$past(reg_wdata_i[6])
    && prediv_run_o == !$past(reg_wdata_i[5])) else $error("predivider wrong");
  chk_cmos_phase: assert property (s_cmos_wr ##1 !reg_wr_i |=>
    clock_pin_true_o == ($past(reg_wdata_i[7:6], 2) == 2'h3 ? 1'b0 : $past(div_clk_i))
    && clock_pin_complement_o == ($past(reg_wdata_i[7:6], 2) == 2'h0 ? $past(div_clk_i)
    : ($past(reg_wdata_i[7:6], 2) == 2'h2 ? 1'b0 : !$past(div_clk_i))))
    else $error("cmos phasing wrong");
  chk_hsw_linear: assert property (hcsl_swing_o < 4'hd && $stable(hcsl_swing_o) |->
    hcsl_swing_mv_o == 10'd200 + 10'd50 * hcsl_swing_o) else $error("hcsl swing mv wrong");
endmodule // odrv_cfg_sva
bind output_driver_ref_divider_cfg odrv_cfg_sva u_sva (.*);

// *** verif/tb_output_driver_ref_divider_cfg.sv ***
/* self-checking bench for the driver config bank.
   assumes byte strobes answered by ack one cycle later. */
`timescale 1ns/1ps
module tb_output_driver_ref_divider_cfg;
  reg core_clk_i, nrst_i, reg_wr_i, reg_rd_i, div_clk_i;
  reg [15:0] reg_addr_i;
  reg [7:0] reg_wdata_i;
  wire [7:0] reg_rdata_o;
  wire reg_ack_o, pin_t, pin_c, h_en, l_en, c_en, bad, bias, term, l_hi, hold, run;
  wire [1:0] lvl;
  wire [9:0] l_mv, lsw_mv, hsw_mv;
  wire [3:0] hsw;
  integer n_fail = 0, comparisons = 0, i;
  reg [15:0] rows [0:5];
  reg [9:0] mv;
  output_driver_ref_divider_cfg dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .div_clk_i(div_clk_i), .clock_pin_true_o(pin_t), .clock_pin_complement_o(pin_c),
    .drv_hcsl_en_o(h_en), .drv_lvds_en_o(l_en), .drv_cmos_en_o(c_en),
    .drv_type_bad_o(bad), .drv_bias_en_o(bias), .hcsl_term_en_o(term),
    .lvds_common_level_o(lvl), .lvds_common_mv_o(l_mv), .lvds_swing_hi_o(l_hi),
    .lvds_swing_mv_o(lsw_mv), .hcsl_swing_o(hsw), .hcsl_swing_mv_o(hsw_mv),
    .prediv_hold_o(hold), .prediv_run_o(run));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      if (n_fail == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // one strobe, then ack expected in the following cycle
  task access(input wr, input [15:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i);
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1;
      check("ack", reg_ack_o, 1'b1);
    end
  endtask
  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, div_clk_i, reg_addr_i, reg_wdata_i} = 0;
    // mode byte, then {hcsl, lvds, cmos, bad, bias, term, level}
    rows[0] = 16'h6c8c;
    rows[1] = 16'h0110;
    rows[2] = 16'h3e4b;
    rows[3] = 16'h8320;
    rows[4] = 16'h1a41;
    rows[5] = 16'h0884;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    access(0, 16'h0000, 0);
    check("mode_rst", reg_rdata_o, 8'h6c);
    access(0, 16'h0001, 0);
    check("swing_rst", reg_rdata_o, 8'hb4);
    check("hsw_rst", hsw_mv, 10'd750);
    access(0, 16'h0006, 0);
    check("pd_rst", {reg_rdata_o, hold, run}, 10'h101);
    for (i = 0; i < 6; i = i + 1) begin
      access(1, 16'h0000, rows[i][15:8]);
      @(posedge core_clk_i);
      #1;
      check("decode", {h_en, l_en, c_en, bad, bias, term, lvl}, rows[i][7:0]);
      mv = rows[i][6] ? 10'd700 + 10'd100 * rows[i][1:0] : 10'd0;
      check("cm_mv", l_mv, mv);
    end
    // swing sweep with lvds selected so both amplitude outputs are live
    access(1, 16'h0000, 8'h2e);
    for (i = 0; i < 16; i = i + 1) begin
      access(1, 16'h0001, {i[3:0], i[0], 3'h4});
      @(posedge core_clk_i);
      #1;
      mv = i < 13 ? 10'(200 + 50 * i) : (i == 13 ? 10'd850 : (i == 14 ? 10'd875 : 10'd900));
      check("hsw", {hsw, hsw_mv}, {i[3:0], mv});
      check("lsw", {l_hi, lsw_mv}, {i[0], i[0] ? 10'd400 : 10'd350});
    end
    // cmos phasing codes at both divider levels
    for (i = 0; i < 8; i = i + 1) begin
      access(1, 16'h0000, {i[2:1], 6'h2f});
      @(posedge core_clk_i);
      div_clk_i <= i[0];
      repeat (2) @(posedge core_clk_i);
      #1;
      check("pin_t", pin_t, i[2:1] == 3 ? 1'b0 : i[0]);
      check("pin_c", pin_c, i[2:1] == 0 ? i[0] : (i[2:1] == 2 ? 1'b0 : !i[0]));
    end
    // predivider bits, ignored bytes and an unmapped offset
    access(1, 16'h0006, 8'hff);
    access(0, 16'h0006, 0);
    check("pd_ff", {reg_rdata_o, hold, run}, 10'h180);
    access(1, 16'h0006, 8'h00);
    check("pd_00", {hold, run}, 2'h3);
    access(1, 16'h0004, 8'hff);
    access(0, 16'h0004, 0);
    check("pd_b0", reg_rdata_o, 8'h00);
    access(0, 16'h0100, 0);
    check("unmapped", reg_rdata_o, 8'h00);
    // second reset in mid-run restores defaults
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    check("rst_hold", {pin_t, pin_c, reg_ack_o, hsw_mv}, {3'h0, 10'd750});
    repeat (2) @(posedge core_clk_i);
    access(0, 16'h0000, 0);
    check("mode_rst2", reg_rdata_o, 8'h6c);
    access(0, 16'h0006, 0);
    check("pd_rst2", {reg_rdata_o, hold, run}, 10'h101);
    final_report;
  end
  // watchdog: the run needs well under 600 cycles
  initial begin
    repeat (2000) @(posedge core_clk_i);
    n_fail = n_fail + 1;
    final_report;
  end
endmodule // tb_output_driver_ref_divider_cfg
